// File: btc_pkg.sv
// Constants and types for the bit test and compare execution unit
package btc_pkg;
   // Register byte offsets
   localparam logic [7:0] BTC_CMD_OFF = 8'h00;
   localparam logic [7:0] BTC_OPA_OFF = 8'h04;
   localparam logic [7:0] BTC_OPB_OFF = 8'h08;
   localparam logic [7:0] BTC_STAT_OFF = 8'h0c;
   localparam logic [7:0] BTC_RES_OFF = 8'h10;
   localparam logic [7:0] BTC_LIT_OFF = 8'h14;
   localparam logic [7:0] BTC_CYC_OFF = 8'h18;
   // Command word fields
   localparam int BTC_OP_LSB = 0;
   localparam int BTC_BIT_LSB = 5;
   localparam int BTC_L5_LSB = 9;
   localparam int BTC_VAR_BIT = 14;
   localparam int BTC_TWO_BIT = 15;
   localparam int BTC_USEL_BIT = 16;
   // Status bit positions
   localparam int BTC_C = 0;
   localparam int BTC_DC = 1;
   localparam int BTC_N = 2;
   localparam int BTC_OV = 3;
   localparam int BTC_Z = 4;
   localparam int BTC_OA = 5;
   localparam int BTC_OB = 6;
   localparam int BTC_SA = 7;
   localparam int BTC_SB = 8;
   localparam int BTC_WATCHDOG_TIMEOUT_FLAG = 9;
   localparam int BTC_SLP = 10;
   localparam int BTC_SKIP = 11;
   localparam int BTC_BUSY = 12;
   localparam int BTC_FLAG_W = 11;
   // Reset values and figures
   localparam logic [10:0] BTC_FLAG_RST = 11'h000;
   localparam logic [1:0] BTC_RESP_OK = 2'b00;
   localparam logic [1:0] BTC_RESP_ERR = 2'b10;
   localparam logic [1:0] BTC_CYC_ONE = 2'd1;
   localparam logic [1:0] BTC_CYC_TWO = 2'd2;
   localparam logic [1:0] BTC_CYC_THREE = 2'd3;
   localparam logic [15:0] BTC_BCD_LO = 16'h0006;
   localparam logic [15:0] BTC_BCD_HI = 16'h0060;
   // Operation codes
   typedef enum logic [4:0] {
      BTC_SKIP_CLR = 5'b00000, BTC_SKIP_SET = 5'b00001,
      BTC_TEST_SET = 5'b00010, BTC_CALL_DIR = 5'b00011,
      BTC_CALL_IND = 5'b00100, BTC_ZERO = 5'b00101,
      BTC_CLR_ACC = 5'b00110, BTC_WDT_KICK = 5'b00111,
      BTC_CMP = 5'b01000, BTC_CMP_ZERO = 5'b01001,
      BTC_CMP_BOR = 5'b01010, BTC_SK_EQ = 5'b01011,
      BTC_SK_NE = 5'b01100, BTC_SK_GT = 5'b01101,
      BTC_SK_LT = 5'b01110, BTC_DAJ = 5'b01111,
      BTC_DEC = 5'b10000
   } btc_op_t;
endpackage

// File: btc_exec.sv
// Bit test, call, clear, compare, decimal adjust and decrement unit
// Contract
// (RULE_01) Skip-if-clear skips when selected bit zero
// (RULE_02) Skip-if-set skips when bit one, no flags
// (RULE_03) Test-then-set copies bit to C or Z
// (RULE_04) Direct call: 23-bit target, two cycles
// (RULE_05) Indirect call: register target, two cycles
// (RULE_06) Clear writes zero, flags untouched
// (RULE_07) Accumulator clear updates OA, OB, SA, SB
// (RULE_08) Watchdog kick restarts timer, clears WATCHDOG_TIMEOUT_FLAG, sleep
// (RULE_09) Compare subtracts, updates C DC N OV Z
// (RULE_10) Compare-with-zero updates flags, stores nothing
// (RULE_11) Compare-with-borrow: base minus source minus not C
// (RULE_12) Equal/unequal skip, no flag change
// (RULE_13) Greater/less skip, no flag change
// (RULE_14) Decimal adjust to packed BCD, C only
// (RULE_15) Decrement by one, updates five flags
// (RULE_16) Taken skip costs two or three cycles
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module btc_exec
   import btc_pkg::*;
#(
   parameter int WDT_CYCLES = 65536
)(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic awvalid,
   input wire logic [7:0] awaddr,
   output logic awready,
   // Write data channel
   input wire logic wvalid,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic wready,
   // Write response channel
   output logic bvalid,
   output logic [1:0] bresp,
   input wire logic bready,
   // Read address channel
   input wire logic arvalid,
   input wire logic [7:0] araddr,
   output logic arready,
   // Read data channel
   output logic rvalid,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic rready
);
   // Subtract with carry-in; returns {Z,OV,N,DC,C,diff}
   // Flag order matches the status bit order, so [20:16] drops in
   function automatic logic [20:0] sub_f(input logic [15:0] a,
      input logic [15:0] b, input logic cin);
      logic [16:0] s;
      logic [4:0] lo;
      s = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
      lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      sub_f = {s[15:0] == 16'h0000,
         (a[15] != b[15]) && (s[15] != a[15]),
         s[15], lo[4], s[16], s[15:0]};
   endfunction

   // Bus side state
   logic aw_got_reg, aw_got_next; // Address held
   logic w_got_reg, w_got_next; // Data held
   logic [7:0] wa_reg, wa_next; // Held write address
   logic [31:0] wd_reg, wd_next; // Held write data
   logic [3:0] ws_reg, ws_next; // Held strobes
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // Execution state
   logic [15:0] opa_reg, opa_next; // Base, file or named operand
   logic [15:0] opb_reg, opb_next; // Source or default operand
   logic [22:0] lit_reg, lit_next; // Direct call literal
   logic [10:0] flg_reg, flg_next; // Status flags
   logic [15:0] res_reg, res_next; // Last result
   logic [22:0] pc_reg, pc_next; // Last call target
   logic skip_reg, skip_next; // Last instruction skipped
   logic [1:0] cyc_reg, cyc_next; // Cycles of last instruction
   logic [1:0] busy_reg, busy_next; // Cycles still to run
   logic [31:0] wdt_reg, wdt_next; // Watchdog count
   logic exec_reg, exec_next; // Helper: executed last cycle
   btc_op_t op_reg, op_next; // Helper: last operation
   // Decode of the command being written
   logic do_wr, exec;
   logic [31:0] cmd;
   btc_op_t op;
   logic [3:0] bsel;
   logic [15:0] srcb, tmp;
   logic [20:0] sr;
   logic tst, cad;

   assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
   assign cmd = wd_reg;
   assign op = btc_op_t'(cmd[BTC_OP_LSB +: 5]);
   assign bsel = cmd[BTC_BIT_LSB +: 4];
   assign exec = do_wr && wa_reg == BTC_CMD_OFF && busy_reg == 2'd0;
   // Literal replaces the source operand when selected
   assign srcb = cmd[BTC_USEL_BIT] ? {11'h000, cmd[BTC_L5_LSB +: 5]}
      : opb_reg;

   // AXI write path: address and data taken in either order
   always_comb
   begin
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      wa_next = wa_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (awvalid && awready_reg)
      begin
         aw_got_next = 1'b1;
         wa_next = {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready_reg)
      begin
         w_got_next = 1'b1;
         wd_next = wdata;
         ws_next = wstrb;
      end
      // Both halves held: perform and answer next cycle
      if (do_wr)
      begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (wa_reg > BTC_CYC_OFF) ? BTC_RESP_ERR : BTC_RESP_OK;
      end
      else if (bvalid_reg && bready)
      begin
         bvalid_next = 1'b0;
      end
      // No new halves until the answer is gone
      awready_next = !aw_got_next && !bvalid_next;
      wready_next = !w_got_next && !bvalid_next;
   end

   // AXI read path: one read in flight, answer one cycle after
   always_comb
   begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (arvalid && arready_reg)
      begin
         rvalid_next = 1'b1;
         rresp_next = BTC_RESP_OK;
         unique case ({araddr[7:2], 2'b00})
            BTC_CMD_OFF: rdata_next = {27'h0, op_reg};
            BTC_OPA_OFF: rdata_next = {16'h0000, opa_reg};
            BTC_OPB_OFF: rdata_next = {16'h0000, opb_reg};
            BTC_STAT_OFF: rdata_next = {19'h0, busy_reg != 2'd0,
               skip_reg, flg_reg};
            BTC_RES_OFF: rdata_next = {16'h0000, res_reg};
            BTC_LIT_OFF: rdata_next = {9'h000, pc_reg};
            BTC_CYC_OFF: rdata_next = {30'h0, cyc_reg};
            default:
            begin
               // Unmapped: zero data, slave error
               rdata_next = 32'h0000_0000;
               rresp_next = BTC_RESP_ERR;
            end
         endcase
      end
      else if (rvalid_reg && rready)
      begin
         rvalid_next = 1'b0;
      end
      arready_next = !rvalid_next;
   end

   // Operand and configuration writes
   always_comb
   begin
      opa_next = opa_reg;
      opb_next = opb_reg;
      lit_next = lit_reg;
      // Only full low halfword writes land; partial strobes ignored
      if (do_wr && ws_reg[1:0] == 2'b11)
      begin
         if (wa_reg == BTC_OPA_OFF)
            opa_next = wd_reg[15:0];
         if (wa_reg == BTC_OPB_OFF)
            opb_next = wd_reg[15:0];
         if (wa_reg == BTC_LIT_OFF && ws_reg[2])
            lit_next = wd_reg[22:0];
      end
   end

   // Instruction execution on a command write
   always_comb
   begin
      flg_next = flg_reg;
      res_next = res_reg;
      pc_next = pc_reg;
      skip_next = skip_reg;
      cyc_next = cyc_reg;
      busy_next = (busy_reg != 2'd0) ? busy_reg - 2'd1 : 2'd0;
      op_next = op_reg;
      exec_next = exec;
      wdt_next = wdt_reg + 32'd1;
      tst = opa_reg[bsel];
      sr = sub_f(opa_reg, srcb, 1'b1);
      tmp = 16'h0000;
      cad = 1'b0;
      // Software may rewrite the flags directly
      if (do_wr && wa_reg == BTC_STAT_OFF && ws_reg[1:0] == 2'b11)
         flg_next = wd_reg[BTC_FLAG_W-1:0];
      if (exec)
      begin
         op_next = op;
         skip_next = 1'b0;
         cyc_next = BTC_CYC_ONE;
         unique case (op)
            BTC_SKIP_CLR: skip_next = !tst; // RULE_01
            BTC_SKIP_SET: skip_next = tst; // RULE_02
            BTC_TEST_SET:
            begin
               // Variant picks C, otherwise Z takes the inverse
               if (cmd[BTC_VAR_BIT])
                  flg_next[BTC_C] = tst; // RULE_03
               else
                  flg_next[BTC_Z] = !tst; // RULE_03
               res_next = opa_reg | (16'h0001 << bsel); // RULE_03
            end
            BTC_CALL_DIR:
            begin
               pc_next = lit_reg; // RULE_04
               cyc_next = BTC_CYC_TWO; // RULE_04
            end
            BTC_CALL_IND:
            begin
               pc_next = {7'h00, opa_reg}; // RULE_05
               cyc_next = BTC_CYC_TWO; // RULE_05
            end
            BTC_ZERO: res_next = 16'h0000; // RULE_06
            BTC_CLR_ACC:
            begin
               // Cleared accumulator loses overflow and saturation
               if (cmd[BTC_VAR_BIT])
               begin
                  flg_next[BTC_OB] = 1'b0; // RULE_07
                  flg_next[BTC_SB] = 1'b0; // RULE_07
               end
               else
               begin
                  flg_next[BTC_OA] = 1'b0; // RULE_07
                  flg_next[BTC_SA] = 1'b0; // RULE_07
               end
            end
            BTC_WDT_KICK:
            begin
               wdt_next = 32'd0; // RULE_08
               flg_next[BTC_WATCHDOG_TIMEOUT_FLAG] = 1'b0; // RULE_08
               flg_next[BTC_SLP] = 1'b0; // RULE_08
            end
            BTC_CMP: flg_next[4:0] = sr[20:16]; // RULE_09
            BTC_CMP_ZERO:
               flg_next[4:0] = sub_f(opa_reg, 16'h0000, 1'b1)
                  [20:16]; // RULE_10
            BTC_CMP_BOR:
            begin
               // Z can only stay set, so chained compares work
               sr = sub_f(opa_reg, srcb, flg_reg[BTC_C]); // RULE_11
               flg_next[3:0] = sr[19:16]; // RULE_11
               flg_next[BTC_Z] = flg_reg[BTC_Z] && sr[20]; // RULE_11
            end
            BTC_SK_EQ: skip_next = opa_reg == opb_reg; // RULE_12
            BTC_SK_NE: skip_next = opa_reg != opb_reg; // RULE_12
            BTC_SK_GT:
               skip_next = $signed(opa_reg) > $signed(opb_reg); // RULE_13
            BTC_SK_LT:
               skip_next = $signed(opa_reg) < $signed(opb_reg); // RULE_13
            BTC_DAJ:
            begin
               // Low byte adjusted; carry only ever set
               tmp = {8'h00, opa_reg[7:0]};
               if (tmp[3:0] > 4'h9 || flg_reg[BTC_DC])
                  tmp = tmp + BTC_BCD_LO; // RULE_14
               if (tmp[8:4] > 5'h09 || flg_reg[BTC_C])
               begin
                  tmp = tmp + BTC_BCD_HI; // RULE_14
                  cad = 1'b1;
               end
               res_next = {opa_reg[15:8], tmp[7:0]}; // RULE_14
               flg_next[BTC_C] = flg_reg[BTC_C] || cad || tmp[8]; // RULE_14
            end
            BTC_DEC:
            begin
               sr = sub_f(opa_reg, 16'h0001, 1'b1); // RULE_15
               res_next = sr[15:0]; // RULE_15
               flg_next[4:0] = sr[20:16]; // RULE_15
            end
            default: cyc_next = BTC_CYC_ONE; // Unknown code: no-op
         endcase
         // Skipped instruction length sets the cost
         if (skip_next)
            cyc_next = cmd[BTC_TWO_BIT] ? BTC_CYC_THREE
               : BTC_CYC_TWO; // RULE_16
         busy_next = cyc_next - 2'd1;
      end
      // Timeout set wins over any clear in the same cycle
      if (wdt_reg >= WDT_CYCLES - 1)
      begin
         flg_next[BTC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
         wdt_next = 32'd0;
      end
   end

   // Register every group
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         wa_reg <= 8'h00;
         wd_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= BTC_RESP_OK;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= BTC_RESP_OK;
         opa_reg <= 16'h0000;
         opb_reg <= 16'h0000;
         lit_reg <= 23'h000000;
         flg_reg <= BTC_FLAG_RST;
         res_reg <= 16'h0000;
         pc_reg <= 23'h000000;
         skip_reg <= 1'b0;
         cyc_reg <= 2'd0;
         busy_reg <= 2'd0;
         wdt_reg <= 32'd0;
         exec_reg <= 1'b0;
         op_reg <= BTC_SKIP_CLR;
      end
      else
      begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         wa_reg <= wa_next;
         wd_reg <= wd_next;
         ws_reg <= ws_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         opa_reg <= opa_next;
         opb_reg <= opb_next;
         lit_reg <= lit_next;
         flg_reg <= flg_next;
         res_reg <= res_next;
         pc_reg <= pc_next;
         skip_reg <= skip_next;
         cyc_reg <= cyc_next;
         busy_reg <= busy_next;
         wdt_reg <= wdt_next;
         exec_reg <= exec_next;
         op_reg <= op_next;
      end
   end

   // Outputs straight from flops
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // Checks on executed instructions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   skip_clear_a: assert property (exec_reg && op_reg == BTC_SKIP_CLR
      |-> skip_reg == !opa_reg[$past(bsel)] && flg_reg == $past(flg_reg))
      else $error("skip clear wrong"); // RULE_01
   skip_set_a: assert property (exec_reg && op_reg == BTC_SKIP_SET
      |-> skip_reg == opa_reg[$past(bsel)])
      else $error("skip set wrong"); // RULE_02
   test_set_a: assert property (exec_reg && op_reg == BTC_TEST_SET
      |-> res_reg[$past(bsel)])
      else $error("tested bit not set"); // RULE_03
   call_cycles_a: assert property (exec_reg && (op_reg == BTC_CALL_DIR
      || op_reg == BTC_CALL_IND) |-> cyc_reg == 2'd2 ##1 busy_reg == 2'd0)
      else $error("call not two cycles"); // RULE_04
   call_ind_a: assert property (exec_reg && op_reg == BTC_CALL_IND
      |-> pc_reg[15:0] == opa_reg && flg_reg == $past(flg_reg))
      else $error("indirect target wrong"); // RULE_05
   zero_res_a: assert property (exec_reg && op_reg == BTC_ZERO
      |-> res_reg == 16'h0000 && flg_reg == $past(flg_reg))
      else $error("clear wrong"); // RULE_06
   wdt_kick_a: assert property (exec_reg && op_reg == BTC_WDT_KICK
      |-> !flg_reg[BTC_SLP] && wdt_reg == 32'd0)
      else $error("watchdog not restarted"); // RULE_08
   cmp_zero_a: assert property (exec_reg && op_reg == BTC_CMP_ZERO
      |-> flg_reg[BTC_Z] == (opa_reg == 16'h0000) && flg_reg[BTC_C])
      else $error("compare zero flags"); // RULE_10
   dec_res_a: assert property (exec_reg && op_reg == BTC_DEC
      |-> res_reg == opa_reg - 16'h0001)
      else $error("decrement wrong"); // RULE_15
   skip_cost_a: assert property (exec_reg && skip_reg
      |-> cyc_reg == ($past(cmd[BTC_TWO_BIT]) ? 2'd3 : 2'd2))
      else $error("skip cost wrong"); // RULE_16
endmodule // btc_exec

// File: btc_exec_test.sv
// Self-checking bench for the bit test and compare unit
`timescale 1ns/1ns
module btc_exec_test;
   import btc_pkg::*;
   // Watchdog count longer than the instruction tests, so no timeout
   // lands in their status checks; the final wait still sees one
   localparam int WDT = 4096;
   localparam int LIMIT = 20000;
   // Clock and reset
   logic aclk = 0;
   logic aresetn = 0;
   // Bus master drive
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   // Slave answers
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, st, cy, rs, t;
   // Scratch for expectations
   logic sk;
   logic [20:0] f;
   logic [15:0] ta [3] = '{16'hfff0, 16'h0005, 16'h0005};
   logic [15:0] tb [3] = '{16'h0005, 16'h0005, 16'hfff0};
   logic [15:0] va [5] = '{16'h5, 16'h3, 16'h8000, 16'h7, 16'h0};
   logic [15:0] vb [5] = '{16'h3, 16'h5, 16'h1, 16'h7, 16'h1};
   logic [4:0] ops [3] = '{BTC_CMP, BTC_CMP_ZERO, BTC_DEC};
   int err_count = 0;
   int n_checks = 0;
   int cyc_cnt = 0;

   always #20 aclk = ~aclk;

   btc_exec #(.WDT_CYCLES(WDT)) dut (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awaddr(awaddr), .awready(awready),
      .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wready(wready),
      .bvalid(bvalid), .bresp(bresp), .bready(bready),
      .arvalid(arvalid), .araddr(araddr), .arready(arready),
      .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));

   // Verdict and end of run, shared by main sequence and timeout
   task automatic close_out();
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Compare with case inequality so unknowns never match
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic done;
      done = 0;
      @(posedge aclk);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= d;
      wstrb <= s;
      bready <= 1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 0;
         if (wvalid && wready)
            wvalid <= 0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 0;
            done = 1;
         end
      end
   endtask

   // Read: rready held until the data is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic done;
      done = 0;
      @(posedge aclk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 0;
         if (rvalid && rready)
         begin
            d = rdata;
            resp = rresp;
            rready <= 0;
            done = 1;
         end
      end
   endtask

   // Issue one instruction, then collect status, cycles and result
   task automatic run(input logic [31:0] cmd);
      wr(BTC_CMD_OFF, cmd, 4'hf);
      rd(BTC_STAT_OFF, st);
      rd(BTC_CYC_OFF, cy);
      rd(BTC_RES_OFF, rs);
   endtask

   // Command word: op, bit position, variant, two-word follower
   function automatic logic [31:0] cw(input logic [4:0] op,
      input logic [3:0] bp, input logic v, input logic tw);
      cw = {16'h0, tw, v, 5'h0, bp, op};
   endfunction

   // Reference subtract: {difference, Z, OV, N, DC, C}, C is no borrow
   function automatic logic [20:0] sub(input logic [15:0] a,
      input logic [15:0] b, input logic ci);
      logic [16:0] r;
      logic [4:0] d;
      r = {1'b0, a} + {1'b0, ~b} + 17'(ci);
      d = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
      sub = {r[15:0], r[15:0] == 16'h0,
         (a[15] != b[15]) && (r[15] != a[15]), r[15], d[4], r[16]};
   endfunction

   // Hang guard
   always @(posedge aclk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == LIMIT)
      begin
         err_count++;
         close_out();
      end
   end

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      // Reset state and unmapped place
      rd(BTC_STAT_OFF, st);
      check(st, 32'h0);
      rd(8'h1c, t);
      check({30'h0, resp}, {30'h0, BTC_RESP_ERR});
      check(t, 32'h0);
      wr(8'h1c, 32'h1, 4'hf);
      check({30'h0, resp}, {30'h0, BTC_RESP_ERR});
      // Watchdog kick clears timeout and sleep
      wr(BTC_STAT_OFF, 32'h600, 4'hf);
      run(cw(BTC_WDT_KICK, 4'h0, 1'b0, 1'b0));
      check(st & 32'h600, 32'h0);
      check(cy, 1);
      // Bit skips over both follower sizes, flags preset nonzero
      wr(BTC_STAT_OFF, 32'h15, 4'hf);
      wr(BTC_OPA_OFF, 32'h10, 4'hf);
      for (int i = 0; i < 8; i++)
      begin
         sk = i[0] ? i[1] : !i[1];
         run(cw(5'(i[0]), i[1] ? 4'd4 : 4'd3, 1'b0, i[2]));
         check(st & 32'h9ff, {20'h0, sk, 2'h0, 9'h15});
         check(cy, sk ? (i[2] ? 3 : 2) : 1);
      end
      // Register compare skips, signed relations
      for (int j = 0; j < 3; j++)
      begin
         wr(BTC_OPA_OFF, {16'h0, ta[j]}, 4'hf);
         wr(BTC_OPB_OFF, {16'h0, tb[j]}, 4'hf);
         for (int k = 0; k < 4; k++)
         begin
            case (k)
               0: sk = ta[j] == tb[j];
               1: sk = ta[j] != tb[j];
               2: sk = $signed(ta[j]) > $signed(tb[j]);
               default: sk = $signed(ta[j]) < $signed(tb[j]);
            endcase
            run(cw(5'(11 + k), 4'h0, 1'b0, 1'b1));
            check(st & 32'h9ff, {20'h0, sk, 2'h0, 9'h15});
            check(cy, sk ? 3 : 1);
         end
      end
      // Test then set to carry, then to zero
      wr(BTC_STAT_OFF, 32'h1f, 4'hf);
      wr(BTC_OPA_OFF, 32'h0, 4'hf);
      run(cw(BTC_TEST_SET, 4'd5, 1'b1, 1'b0));
      check(st & 32'h1ff, 32'h1e);
      check(rs & 32'hffff, 32'h20);
      wr(BTC_STAT_OFF, 32'h1f, 4'hf);
      wr(BTC_OPA_OFF, 32'h20, 4'hf);
      run(cw(BTC_TEST_SET, 4'd5, 1'b0, 1'b0));
      check(st & 32'h1ff, 32'h0f);
      check(rs & 32'hffff, 32'h20);
      // Calls: widest direct target, then register target
      wr(BTC_STAT_OFF, 32'h1f, 4'hf);
      wr(BTC_LIT_OFF, 32'h7fffff, 4'hf);
      run(cw(BTC_CALL_DIR, 4'h0, 1'b0, 1'b0));
      check(cy, 2);
      check(st & 32'h1ff, 32'h1f);
      rd(BTC_LIT_OFF, t);
      check(t, 32'h7fffff);
      wr(BTC_OPA_OFF, 32'h1234, 4'hf);
      run(cw(BTC_CALL_IND, 4'h0, 1'b0, 1'b0));
      check(cy, 2);
      check(st & 32'h1ff, 32'h1f);
      rd(BTC_LIT_OFF, t);
      check(t, 32'h1234);
      // Clear after a nonzero result
      run(cw(BTC_ZERO, 4'h0, 1'b0, 1'b0));
      check(rs, 32'h0);
      check(st & 32'h1ff, 32'h1f);
      check(cy, 1);
      // Accumulator clears touch only the chosen pair
      wr(BTC_STAT_OFF, 32'h1e0, 4'hf);
      run(cw(BTC_CLR_ACC, 4'h0, 1'b0, 1'b0));
      check(st & 32'h1ff, 32'h140);
      run(cw(BTC_CLR_ACC, 4'h0, 1'b1, 1'b0));
      check(st & 32'h1ff, 32'h0);
      check(cy, 1);
      // Compare, compare with zero, decrement over edge operands
      for (int m = 0; m < 15; m++)
      begin
         wr(BTC_OPA_OFF, {16'h0, va[m % 5]}, 4'hf);
         wr(BTC_OPB_OFF, {16'h0, vb[m % 5]}, 4'hf);
         f = sub(va[m % 5], m < 5 ? vb[m % 5] : 16'(m >= 10), 1'b1);
         run(cw(ops[m / 5], 4'h0, 1'b0, 1'b0));
         check(st & 32'h1ff, {27'h0, f[4:0]});
         if (m >= 10)
            check(rs & 32'hffff, {16'h0, f[20:5]});
      end
      // Compare against the short literal
      wr(BTC_OPA_OFF, 32'h1f, 4'hf);
      run(cw(BTC_CMP, 4'h0, 1'b0, 1'b0) | 32'h13e00);
      check(st & 32'h1ff, 32'h13);
      // Borrow compare: inverted carry in, zero only kept
      for (int n = 0; n < 2; n++)
      begin
         wr(BTC_STAT_OFF, n ? 32'h01 : 32'h10, 4'hf);
         wr(BTC_OPA_OFF, 32'h5, 4'hf);
         wr(BTC_OPB_OFF, n ? 32'h5 : 32'h4, 4'hf);
         f = sub(16'h5, n ? 16'h5 : 16'h4, n[0]);
         f[4] = f[4] & !n[0];
         run(cw(BTC_CMP_BOR, 4'h0, 1'b0, 1'b0));
         check(st & 32'h1ff, {27'h0, f[4:0]});
         check(cy, 1);
      end
      // Decimal adjust of low digit, then carry out of high digit
      wr(BTC_STAT_OFF, 32'h0, 4'hf);
      wr(BTC_OPA_OFF, 32'h1a, 4'hf);
      run(cw(BTC_DAJ, 4'h0, 1'b0, 1'b0));
      check(rs & 32'hffff, 32'h20);
      check(st & 32'h1ff, 32'h0);
      wr(BTC_OPA_OFF, 32'ha0, 4'hf);
      run(cw(BTC_DAJ, 4'h0, 1'b0, 1'b0));
      check(rs & 32'hff, 32'h0);
      check(st & 32'h1ff, 32'h1);
      // Without a kick the watchdog must time out
      repeat (2 * WDT) @(posedge aclk);
      rd(BTC_STAT_OFF, st);
      check(st & 32'h200, 32'h200);
      close_out();
   end
endmodule // btc_exec_test
